// file: shared/rst_seq_pkg.sv
package rst_seq_pkg;
   localparam int n_cores = 3;
   localparam int boot_w = 3;
   localparam int div_w = 8;
   localparam int mult_w = 8;
   // boot select encodings
   localparam logic [2:0] boot_none = 3'h0;
   localparam logic [2:0] boot_spi_flash = 3'h1;
   localparam logic [2:0] boot_spi_host = 3'h2;
   localparam logic [2:0] boot_uart_host = 3'h3;
   localparam logic [2:0] boot_link_host = 3'h4;
   localparam logic [2:0] boot_ospi_flash = 3'h5;
   localparam logic [2:0] boot_emmc = 3'h6;
   localparam logic [2:0] boot_reserved = 3'h7;
   // reset sequencing timing
   localparam int clk_mhz = 25;
   localparam int sys_rst_ns = 400;
   localparam int sys_rst_cycles = (sys_rst_ns * clk_mhz + 999) / 1000;
   localparam int lock_ns = 2000;
   localparam int lock_cycles = (lock_ns * clk_mhz + 999) / 1000;
   localparam int cnt_w = 8;
   // reset-time clock defaults
   localparam logic [7:0] mult_rst = 8'h10;
   localparam logic [7:0] div_rst = 8'h01;
   localparam logic [1:0] clkout_sel_ref = 2'h0;
   localparam logic [1:0] clkout_sel_output_clk = 2'h1;
   localparam logic [1:0] clkout_sel_core = 2'h2;
   localparam logic [1:0] clkout_sel_ddr = 2'h3;

   typedef enum logic [2:0] {
      st_hw_reset = 3'h0,
      st_pll_lock = 3'h1,
      st_sys_reset = 3'h2,
      st_boot = 3'h3,
      st_run = 3'h4
   } seq_state_t;

   typedef enum logic [1:0] {
      cls_none = 2'h0,
      cls_flash = 2'h1,
      cls_host = 2'h2
   } boot_class_t;
endpackage

// file: rtl/pin_sync3.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync3 #(
   parameter int width = 1,
   parameter logic [width-1:0] init = '0
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [width-1:0] pin,
   output logic [width-1:0] level
);
   logic [width-1:0] s1_q, s2_q, s3_q, lvl_q;
   logic [width-1:0] lvl_d;

   // a change counts only once stages two and three agree
   always_comb begin
      lvl_d = lvl_q;
      for (int i = 0; i < width; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            lvl_d[i] = s3_q[i];
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_q <= init;
         s2_q <= init;
         s3_q <= init;
         lvl_q <= init;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   assign level = lvl_q;
endmodule
`default_nettype wire

// file: rtl/clk_div_en.sv
`timescale 1ns/100ps
`default_nettype none
module clk_div_en #(
   parameter int div_w = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic run,
   input wire logic tick,
   input wire logic [div_w-1:0] divide,
   output logic en
);
   logic [div_w-1:0] cnt_q, cnt_d;
   logic en_q, en_d;

   // one pulse every divide ticks; a divide of zero acts as one
   always_comb begin
      cnt_d = cnt_q;
      en_d = 1'b0;
      if (!run) begin
         cnt_d = '0;
      end else if (tick) begin
         if (cnt_q + div_w'(1) >= divide) begin
            cnt_d = '0;
            en_d = 1'b1;
         end else begin
            cnt_d = cnt_q + div_w'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= '0;
         en_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         en_q <= en_d;
      end
   end

   assign en = en_q;
endmodule
`default_nettype wire

// file: rtl/reset_boot_clock_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// [R1] system reset defaults every unit except the reset control unit itself
// [R2] hardware reset defaults everything, reset history included; boot_mode keeps its last value until resampled at the end of system reset
// [R3] core-only reset holds one core and blocks bus access to it
// [R4] system reset from software write, power, event, trigger or emulator
// [R5] low level on hardware reset input means hardware reset asserted
// [R6] release of hardware reset starts the pll locking sequence
// [R7] board releases hardware reset only after supplies and clocks valid
// [R8] clock settings are held then stepped smoothly to new values
// [R9] pll clock is multiplied reference, divided into core, sys, ddr, out
// [R10] clock out pin carries reference clock zero until reprogrammed
// [R11] boot select sampled on power-on and software resets
// [R12] boot select 000 none, 001-110 the listed flash and host modes
// [R13] flash modes fetch actively, host modes accept passively
// [R14] only core 0 runs boot loading, other cores stay out
// [R15] boot select 111 reserved, no boot loading
module reset_boot_clock_sequencer #(
   parameter int n_cores = rst_seq_pkg::n_cores,
   parameter int div_w = rst_seq_pkg::div_w,
   parameter int mult_w = rst_seq_pkg::mult_w
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic hw_reset_n_in,
   input wire logic [2:0] boot_select,
   input wire logic ref_clk_in0,
   input wire logic sw_reset_req,
   input wire logic power_mgmt_unit_req,
   input wire logic system_event_ctrl_req,
   input wire logic trigger_routing_unit_req,
   input wire logic emulator_req,
   input wire logic [n_cores-1:0] core_reset_req,
   input wire logic clk_cfg_wr,
   input wire logic [mult_w-1:0] cfg_mult,
   input wire logic [div_w-1:0] cfg_core_div,
   input wire logic [div_w-1:0] cfg_sys_div,
   input wire logic [div_w-1:0] cfg_ddr_div,
   input wire logic [div_w-1:0] cfg_out_div,
   input wire logic [1:0] cfg_clkout_sel,
   input wire logic boot_done,
   output logic sys_reset_out,
   output logic hw_reset_out,
   output logic [n_cores-1:0] core_reset_out,
   output logic [n_cores-1:0] core_access_block,
   output logic pll_locking,
   output logic pll_locked,
   output logic [mult_w-1:0] pll_mult,
   output logic core_clk_en,
   output logic sys_clk_en,
   output logic ddr_clk_en,
   output logic output_clk_en,
   output logic clock_out_pin,
   output logic [2:0] boot_mode,
   output logic boot_active,
   output logic boot_fetch,
   output logic boot_accept,
   output logic [1:0] last_reset_cause
);
   localparam logic [7:0] sys_rst_cnt = 8'(rst_seq_pkg::sys_rst_cycles);
   localparam logic [7:0] lock_cnt = 8'(rst_seq_pkg::lock_cycles);

   function automatic rst_seq_pkg::boot_class_t classify(
      input logic [2:0] sel
   );
      case (sel)
         rst_seq_pkg::boot_spi_flash, rst_seq_pkg::boot_ospi_flash,
         rst_seq_pkg::boot_emmc: classify = rst_seq_pkg::cls_flash; // [R13]
         rst_seq_pkg::boot_spi_host, rst_seq_pkg::boot_uart_host,
         rst_seq_pkg::boot_link_host: classify = rst_seq_pkg::cls_host;
         default: classify = rst_seq_pkg::cls_none; // [R12] [R15]
      endcase
   endfunction
   logic hw_rst_lvl;
   logic [2:0] bsel_lvl;
   logic ref_lvl;

   // pins come from the board, outside this clock
   pin_sync3 #(.width(1), .init(1'b0)) u_hwrst_sync (
      .clk(clk),
      .reset_n(reset_n),
      .pin(hw_reset_n_in),
      .level(hw_rst_lvl)
   );
   pin_sync3 #(.width(3), .init(3'h0)) u_bsel_sync (
      .clk(clk),
      .reset_n(reset_n),
      .pin(boot_select),
      .level(bsel_lvl)
   );
   pin_sync3 #(.width(1), .init(1'b0)) u_ref_sync (
      .clk(clk),
      .reset_n(reset_n),
      .pin(ref_clk_in0),
      .level(ref_lvl)
   );

   rst_seq_pkg::seq_state_t st_q, st_d;
   logic [7:0] cnt_q, cnt_d;
   logic por_q, por_d;
   logic [2:0] bmode_q, bmode_d;
   logic [1:0] cause_q, cause_d;
   logic [n_cores-1:0] crst_q, crst_d;
   logic hw_rst_prev_q;
   logic sys_src;
   assign sys_src = sw_reset_req | power_mgmt_unit_req |
                    system_event_ctrl_req | trigger_routing_unit_req |
                    emulator_req; // [R4]

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      por_d = por_q;
      bmode_d = bmode_q;
      cause_d = cause_q;
      crst_d = core_reset_req;
      if (!hw_rst_lvl) begin
         // hardware reset wipes history too
         st_d = rst_seq_pkg::st_hw_reset; // [R5] [R2]
         cnt_d = '0;
         por_d = 1'b1;
         cause_d = 2'h0;
         crst_d = '1;
      end else begin
         case (st_q)
            rst_seq_pkg::st_hw_reset: begin
               crst_d = '1;
               if (!hw_rst_prev_q) begin
                  st_d = rst_seq_pkg::st_pll_lock; // [R6]
                  cnt_d = '0;
               end
            end
            rst_seq_pkg::st_pll_lock: begin
               crst_d = '1;
               cnt_d = cnt_q + 8'h01;
               if (cnt_q + 8'h01 >= lock_cnt) begin
                  st_d = rst_seq_pkg::st_sys_reset;
                  cnt_d = '0;
                  cause_d = 2'h1;
               end
            end
            rst_seq_pkg::st_sys_reset: begin
               crst_d = '1;
               cnt_d = cnt_q + 8'h01;
               if (cnt_q + 8'h01 >= sys_rst_cnt) begin
                  // straps caught on power-on or software reset
                  if (por_q || cause_q == 2'h2) begin
                     bmode_d = bsel_lvl; // [R11]
                  end
                  por_d = 1'b0;
                  st_d = rst_seq_pkg::st_boot;
                  cnt_d = '0;
               end
            end
            rst_seq_pkg::st_boot: begin
               // other cores held off while core 0 loads
               crst_d = '1;
               crst_d[0] = core_reset_req[0]; // [R14]
               if (sys_src) begin
                  st_d = rst_seq_pkg::st_sys_reset;
                  cnt_d = '0;
                  cause_d = sw_reset_req ? 2'h2 : 2'h3;
               end else if (boot_done ||
                            classify(bmode_q) == rst_seq_pkg::cls_none) begin
                  st_d = rst_seq_pkg::st_run;
               end
            end
            rst_seq_pkg::st_run: begin
               if (sys_src) begin
                  st_d = rst_seq_pkg::st_sys_reset; // [R4]
                  cnt_d = '0;
                  cause_d = sw_reset_req ? 2'h2 : 2'h3;
               end
            end
            default: begin
               st_d = rst_seq_pkg::st_hw_reset;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= rst_seq_pkg::st_hw_reset;
         cnt_q <= '0;
         por_q <= 1'b1;
         bmode_q <= rst_seq_pkg::boot_none;
         cause_q <= 2'h0;
         crst_q <= '1;
         hw_rst_prev_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         por_q <= por_d;
         bmode_q <= bmode_d;
         cause_q <= cause_d; // [R1] kept across system reset
         crst_q <= crst_d;
         hw_rst_prev_q <= hw_rst_lvl;
      end
   end

   // clock generator: staged settings, multiplier stepped one unit per cycle
   logic [mult_w-1:0] pend_mult_q, pend_mult_d, mult_q, mult_d;
   logic [div_w-1:0] pend_div_q [4];
   logic [div_w-1:0] pend_div_d [4];
   logic [div_w-1:0] div_q [4];
   logic [div_w-1:0] div_d [4];
   logic [1:0] pend_sel_q, pend_sel_d, sel_q, sel_d;
   logic hold_q, hold_d;
   logic in_hw;

   assign in_hw = (st_q == rst_seq_pkg::st_hw_reset);

   always_comb begin
      pend_mult_d = pend_mult_q;
      pend_div_d = pend_div_q;
      pend_sel_d = pend_sel_q;
      mult_d = mult_q;
      div_d = div_q;
      sel_d = sel_q;
      hold_d = hold_q;
      if (in_hw) begin
         pend_mult_d = rst_seq_pkg::mult_rst;
         mult_d = rst_seq_pkg::mult_rst;
         for (int i = 0; i < 4; i++) begin
            pend_div_d[i] = rst_seq_pkg::div_rst;
            div_d[i] = rst_seq_pkg::div_rst;
         end
         pend_sel_d = rst_seq_pkg::clkout_sel_ref; // [R10]
         sel_d = rst_seq_pkg::clkout_sel_ref;
         hold_d = 1'b0;
      end else if (clk_cfg_wr) begin
         // write only stages; pll keeps running the old point
         pend_mult_d = cfg_mult; // [R8]
         pend_div_d[0] = cfg_core_div;
         pend_div_d[1] = cfg_sys_div;
         pend_div_d[2] = cfg_ddr_div;
         pend_div_d[3] = cfg_out_div;
         pend_sel_d = cfg_clkout_sel;
         hold_d = 1'b1;
      end else if (hold_q) begin
         hold_d = 1'b0;
      end else begin
         // step multiplier by one per cycle to avoid a lock jump
         if (mult_q < pend_mult_q) begin
            mult_d = mult_q + mult_w'(1); // [R8]
         end else if (mult_q > pend_mult_q) begin
            mult_d = mult_q - mult_w'(1);
         end
         if (mult_q == pend_mult_q) begin
            div_d = pend_div_q;
            sel_d = pend_sel_q;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pend_mult_q <= rst_seq_pkg::mult_rst;
         mult_q <= rst_seq_pkg::mult_rst;
         for (int i = 0; i < 4; i++) begin
            pend_div_q[i] <= rst_seq_pkg::div_rst;
            div_q[i] <= rst_seq_pkg::div_rst;
         end
         pend_sel_q <= rst_seq_pkg::clkout_sel_ref;
         sel_q <= rst_seq_pkg::clkout_sel_ref;
         hold_q <= 1'b0;
      end else begin
         pend_mult_q <= pend_mult_d;
         mult_q <= mult_d;
         pend_div_q <= pend_div_d;
         div_q <= div_d;
         pend_sel_q <= pend_sel_d;
         sel_q <= sel_d;
         hold_q <= hold_d;
      end
   end
   logic run_clk;
   logic [3:0] div_en;
   assign run_clk = (st_q != rst_seq_pkg::st_hw_reset) &&
                    (st_q != rst_seq_pkg::st_pll_lock);

   // pll clock modelled as the system clock; dividers give enables
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_div
         clk_div_en #(.div_w(div_w)) u_div (
            .clk(clk),
            .reset_n(reset_n),
            .run(run_clk),
            .tick(1'b1),
            .divide(div_q[g]),
            .en(div_en[g])
         ); // [R9]
      end
   endgenerate

   logic clkout_q, clkout_d;
   always_comb begin
      case (sel_q)
         rst_seq_pkg::clkout_sel_ref: clkout_d = ref_lvl; // [R10]
         rst_seq_pkg::clkout_sel_output_clk: clkout_d = div_en[3];
         rst_seq_pkg::clkout_sel_core: clkout_d = div_en[0];
         default: clkout_d = div_en[2];
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         clkout_q <= 1'b0;
      end else begin
         clkout_q <= clkout_d;
      end
   end

   rst_seq_pkg::boot_class_t cls;
   assign cls = classify(bmode_q);

   assign hw_reset_out = in_hw; // [R2]
   assign sys_reset_out = (st_q != rst_seq_pkg::st_boot) &&
                          (st_q != rst_seq_pkg::st_run); // [R1]
   assign core_reset_out = crst_q; // [R3]
   assign core_access_block = crst_q; // [R3]
   assign pll_locking = (st_q == rst_seq_pkg::st_pll_lock);
   assign pll_locked = run_clk;
   assign pll_mult = mult_q;
   assign core_clk_en = div_en[0];
   assign sys_clk_en = div_en[1];
   assign ddr_clk_en = div_en[2];
   assign output_clk_en = div_en[3];
   assign clock_out_pin = clkout_q;
   assign boot_mode = bmode_q;
   assign boot_active = (st_q == rst_seq_pkg::st_boot) &&
                        (cls != rst_seq_pkg::cls_none); // [R14]
   assign boot_fetch = boot_active && (cls == rst_seq_pkg::cls_flash);
   assign boot_accept = boot_active && (cls == rst_seq_pkg::cls_host);
   assign last_reset_cause = cause_q;
endmodule
`default_nettype wire

// file: dv/board_supervisor.sv
`timescale 1ns/100ps
`default_nettype none
module board_supervisor #(
   parameter int ref_half = 8
) (
   input wire logic clk,
   input wire logic supply_ok,
   input wire logic [2:0] strap,
   output logic hw_reset_n_in,
   output logic [2:0] boot_select,
   output logic ref_clk_in0
);
   int div_cnt;
   int edges;
   initial begin
      hw_reset_n_in = 1'b0;
      ref_clk_in0 = 1'b0;
      div_cnt = 0;
      edges = 0;
   end
   assign boot_select = strap;
   // oscillator runs from power-up, far slower than the system clock
   always @(posedge clk) begin
      div_cnt <= (div_cnt == ref_half - 1) ? 0 : div_cnt + 1;
      if (div_cnt == ref_half - 1) begin
         ref_clk_in0 <= ~ref_clk_in0;
         edges <= (edges < 4) ? edges + 1 : edges;
      end
      // no release until supplies good and reference seen toggling
      hw_reset_n_in <= supply_ok && edges >= 4;
   end
endmodule
`default_nettype wire

// file: dv/seq_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module seq_asserts #(
   parameter int n_cores = 3,
   parameter int mult_w = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic hw_reset_n_in,
   input wire logic ref_clk_in0,
   input wire logic sw_reset_req,
   input wire logic power_mgmt_unit_req,
   input wire logic system_event_ctrl_req,
   input wire logic trigger_routing_unit_req,
   input wire logic emulator_req,
   input wire logic clk_cfg_wr,
   input wire logic sys_reset_out,
   input wire logic hw_reset_out,
   input wire logic [n_cores-1:0] core_reset_out,
   input wire logic [n_cores-1:0] core_access_block,
   input wire logic pll_locking,
   input wire logic [mult_w-1:0] pll_mult,
   input wire logic clock_out_pin,
   input wire logic [2:0] boot_mode,
   input wire logic boot_active,
   input wire logic boot_fetch,
   input wire logic boot_accept
);
   logic [7:0] lock_cnt_q, lock_cnt_d, ref_cnt_q, ref_cnt_d;
   logic ref_last_q;
   logic any_src;
   assign any_src = sw_reset_req | power_mgmt_unit_req |
      system_event_ctrl_req | trigger_routing_unit_req | emulator_req;
   always_comb begin
      lock_cnt_d = pll_locking ? lock_cnt_q + 8'h01 : 8'h00;
      ref_cnt_d = (ref_clk_in0 != ref_last_q) ? 8'h00 :
         (ref_cnt_q == 8'hff ? ref_cnt_q : ref_cnt_q + 8'h01);
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lock_cnt_q <= 8'h00;
         ref_cnt_q <= 8'h00;
         ref_last_q <= 1'b0;
      end else begin
         lock_cnt_q <= lock_cnt_d;
         ref_cnt_q <= ref_cnt_d;
         ref_last_q <= ref_clk_in0;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   AST_PIN_LOW_HW: assert property (
      !hw_reset_n_in [*6] |-> hw_reset_out) else $error("no hw reset");
   AST_LOCK_START: assert property (
      $fell(hw_reset_out) |-> pll_locking) else $error("lock not begun");
   AST_LOCK_LEN: assert property (
      $fell(pll_locking) && !hw_reset_out |->
      lock_cnt_q == rst_seq_pkg::lock_cycles) else $error("lock length");
   AST_SRC_SYSRST: assert property (
      !sys_reset_out && any_src |-> ##[1:3] sys_reset_out)
      else $error("source ignored");
   AST_SYS_HOLD: assert property (
      sys_reset_out && $past(sys_reset_out) |->
      &core_reset_out && &core_access_block) else $error("core free");
   AST_CORE0_BOOT: assert property (
      boot_active && $past(boot_active) |->
      !core_reset_out[0] && &core_reset_out[n_cores-1:1])
      else $error("boot core wrong");
   AST_BOOT_CLASS: assert property (
      boot_active |-> boot_fetch == (boot_mode inside {1, 5, 6}) &&
      boot_accept == (boot_mode inside {2, 3, 4})) else $error("class");
   AST_NO_BOOT: assert property (
      boot_mode == 3'h0 || boot_mode == 3'h7 |-> !boot_active)
      else $error("boot with none");
   AST_MULT_STEP: assert property (
      !hw_reset_out && !$past(hw_reset_out) |->
      pll_mult == $past(pll_mult) || pll_mult == $past(pll_mult) + 1'b1 ||
      pll_mult == $past(pll_mult) - 1'b1) else $error("mult jumped");
   AST_CFG_HELD: assert property (
      clk_cfg_wr && !hw_reset_out |=> $stable(pll_mult))
      else $error("cfg not held");
   // pin reaches clock out five edges later through sync and output flop
   AST_CLKOUT_REF: assert property (
      ref_cnt_q >= 8'h06 && !hw_reset_out |->
      clock_out_pin == $past(ref_clk_in0, 5))
      else $error("clock out not ref");
endmodule
bind reset_boot_clock_sequencer seq_asserts #(.n_cores(n_cores),
   .mult_w(mult_w)) u_asserts (.clk, .reset_n, .hw_reset_n_in, .ref_clk_in0,
   .sw_reset_req, .power_mgmt_unit_req, .system_event_ctrl_req,
   .trigger_routing_unit_req, .emulator_req, .clk_cfg_wr, .sys_reset_out,
   .hw_reset_out, .core_reset_out, .core_access_block, .pll_locking,
   .pll_mult, .clock_out_pin, .boot_mode, .boot_active, .boot_fetch,
   .boot_accept);
`default_nettype wire

// file: dv/reset_boot_clock_sequencer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module reset_boot_clock_sequencer_tb_top;
   logic clk, reset_n, supply_ok, hw_reset_n_in, ref_clk_in0, sw_reset_req;
   logic boot_done, clk_cfg_wr, sys_reset_out, hw_reset_out, pll_locking;
   logic core_clk_en, sys_clk_en, ddr_clk_en, output_clk_en, clock_out_pin;
   logic boot_active, boot_fetch, boot_accept, pll_locked;
   logic [1:0] cfg_clkout_sel, last_reset_cause;
   logic [2:0] strap, boot_select, core_reset_req, core_reset_out;
   logic [2:0] core_access_block, boot_mode;
   logic [3:0] src;
   logic [7:0] cfg_mult, cfg_core_div, cfg_sys_div, cfg_ddr_div;
   logic [7:0] cfg_out_div, pll_mult;
   logic [7:0] n_en [4];
   int error_cnt, n_compared, cyc;
   // strap, then expected active, fetch, accept
   localparam logic [5:0] rows [8] = '{6'h00, 6'h0e, 6'h15, 6'h1d, 6'h25,
      6'h2e, 6'h36, 6'h38};
   board_supervisor u_board (.clk, .supply_ok, .strap, .hw_reset_n_in,
      .boot_select, .ref_clk_in0);
   reset_boot_clock_sequencer u_dut (.clk, .reset_n, .hw_reset_n_in,
      .boot_select, .ref_clk_in0, .sw_reset_req,
      .power_mgmt_unit_req(src[0]), .system_event_ctrl_req(src[1]),
      .trigger_routing_unit_req(src[2]), .emulator_req(src[3]),
      .core_reset_req, .clk_cfg_wr, .cfg_mult, .cfg_core_div, .cfg_sys_div,
      .cfg_ddr_div, .cfg_out_div, .cfg_clkout_sel, .boot_done, .sys_reset_out,
      .hw_reset_out, .core_reset_out, .core_access_block, .pll_locking,
      .pll_locked, .pll_mult, .core_clk_en, .sys_clk_en, .ddr_clk_en,
      .output_clk_en, .clock_out_pin, .boot_mode, .boot_active, .boot_fetch,
      .boot_accept, .last_reset_cause);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // waits are bounded so a stuck sequencer shows as a mismatch
   task automatic wait_sys(input logic lvl);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (sys_reset_out !== lvl && n < 300);
      chk(8'(sys_reset_out), 8'(lvl));
   endtask
   task automatic pulse_src(input int s);
      @(posedge clk);
      if (s == 4) sw_reset_req <= 1'b1;
      else src[s] <= 1'b1;
      @(posedge clk);
      sw_reset_req <= 1'b0;
      src <= 4'h0;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         finish_test();
      end
   end
   initial begin
      error_cnt = 0;
      n_compared = 0;
      cyc = 0;
      reset_n = 1'b0;
      supply_ok = 1'b1;
      strap = 3'h5;
      sw_reset_req = 1'b0;
      src = 4'h0;
      boot_done = 1'b0;
      core_reset_req = 3'h0;
      clk_cfg_wr = 1'b0;
      cfg_mult = 8'h10;
      cfg_core_div = 8'h01;
      cfg_sys_div = 8'h01;
      cfg_ddr_div = 8'h01;
      cfg_out_div = 8'h01;
      cfg_clkout_sel = 2'h0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      #1 chk(8'(hw_reset_out), 8'h01);
      wait_sys(1'b0);
      chk(8'(pll_locked), 8'h01);
      chk(8'(boot_mode), 8'h05);
      chk(8'(last_reset_cause), 8'h01);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         strap <= rows[i][5:3];
         pulse_src(4);
         wait_sys(1'b1);
         wait_sys(1'b0);
         chk(8'(boot_mode), 8'(rows[i][5:3]));
         chk(8'({boot_active, boot_fetch, boot_accept}),
            8'(rows[i][2:0]));
         chk(8'(last_reset_cause), 8'h02);
         @(posedge clk);
         boot_done <= 1'b1;
         @(posedge clk);
         boot_done <= 1'b0;
      end
      // other units must not resample the strap
      strap <= 3'h1;
      for (int k = 0; k < 4; k++) begin
         pulse_src(k);
         wait_sys(1'b1);
         wait_sys(1'b0);
         chk(8'(boot_mode), 8'h07);
         chk(8'(last_reset_cause), 8'h03);
      end
      @(posedge clk);
      core_reset_req <= 3'h5;
      repeat (3) @(posedge clk);
      #1 chk(8'(core_reset_out), 8'h05);
      chk(8'(core_access_block), 8'h05);
      @(posedge clk);
      core_reset_req <= 3'h0;
      clk_cfg_wr <= 1'b1;
      cfg_mult <= 8'h13;
      cfg_core_div <= 8'h02;
      cfg_sys_div <= 8'h03;
      cfg_ddr_div <= 8'h04;
      cfg_out_div <= 8'h05;
      @(posedge clk);
      clk_cfg_wr <= 1'b0;
      #1 chk(pll_mult, 8'h10);
      repeat (20) @(posedge clk);
      #1 chk(pll_mult, 8'h13);
      n_en = '{8'h00, 8'h00, 8'h00, 8'h00};
      repeat (60) begin
         @(posedge clk);
         #1;
         n_en[0] += 8'(core_clk_en);
         n_en[1] += 8'(sys_clk_en);
         n_en[2] += 8'(ddr_clk_en);
         n_en[3] += 8'(output_clk_en);
      end
      chk(n_en[0], 8'd30);
      chk(n_en[1], 8'd20);
      chk(n_en[2], 8'd15);
      chk(n_en[3], 8'd12);
      @(posedge clk);
      supply_ok <= 1'b0;
      repeat (8) @(posedge clk);
      #1 chk(8'(hw_reset_out), 8'h01);
      chk(8'(core_reset_out), 8'h07);
      chk(8'(pll_locked), 8'h00);
      chk(pll_mult, 8'h10);
      @(posedge clk);
      supply_ok <= 1'b1;
      wait_sys(1'b0);
      chk(pll_mult, 8'h10);
      chk(8'(last_reset_cause), 8'h01);
      chk(8'(boot_mode), 8'h01);
      finish_test();
   end
endmodule
`default_nettype wire
